// ===== src/pmic_power_order_sequencer.sv
`timescale 1ns/10ps
`include "seq_consts.svh"
module pmic_power_order_sequencer
  import seq_pkg::*;
#(
  parameter int STEP_CYCLES = `TD_STEP_US * 1000 / `CLK_PERIOD_NS, // cycles per 0.5 ms gap step
  parameter int TW = 20 // gap counter width, holds four steps
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic en_pin,
  input wire logic [2:0] order_strap_pin,
  input wire logic fault_in,
  input wire logic [3:0] ch_good,
  input wire logic [3:0] ch_discharged,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic [3:0] ch_enable,
  output logic seq_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // channels whose order code equals the given position; 000 never matches
  function automatic logic [3:0] chan_mask(input order_codes_t codes, input logic [2:0] pos);
    logic [3:0] m;
    m = 4'h0;
    for (int i = 0; i < 4; i++) begin
      m[i] = (pos != 3'h0) && (codes[3*i +: 3] == pos);
    end
    return m;
  endfunction

  // gap length in cycles from a 2-bit delay field: 0, 0.5, 1, 2 ms
  function automatic logic [TW-1:0] td_cycles(input logic [1:0] td);
    logic [TW-1:0] step;
    step = TW'(STEP_CYCLES);
    unique case (td)
      2'h0: return '0;
      2'h1: return step;
      2'h2: return step << 1;
      2'h3: return step << 2;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers: enable, strap, fault and rail status pins pass two flops first; the register port is not synchronised

  logic [12:0] pin_meta_r; // first stage, read only by the second stage
  logic [12:0] pin_sync_r; // second stage, safe for logic

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end else begin
      pin_meta_r <= {ch_discharged, ch_good, fault_in, order_strap_pin, en_pin};
      pin_sync_r <= pin_meta_r;
    end
  end

  wire en_s = pin_sync_r[0]; // enable level
  wire [2:0] strap_s = pin_sync_r[3:1]; // sensed strap level code
  wire fault_s = pin_sync_r[4]; // protection fault
  wire [3:0] good_s = pin_sync_r[8:5]; // soft-start finished per channel
  wire [3:0] dis_s = pin_sync_r[12:9]; // discharge finished per channel

  ////////////////////////////////////////////////////////////////////////////
  // strap capture and preset lookup

  seq_state_t state_r, state_nxt; // sequencer state, declared here because the strap capture reads it
  logic [2:0] settle_r; // cycles since reset, lets the synchroniser fill
  logic [2:0] strap_sel_r; // captured preset number, frozen until next reset
  wire strap_take = (settle_r == `STRAP_SETTLE_CYC);

  // out-of-range strap codes fall back to the factory preset
  wire [2:0] strap_idx = (strap_s < `PRESET_COUNT) ? strap_s : 3'h0;
  wire order_codes_t preset_codes =
    (strap_idx == 3'h1) ? `PRESET_SEQ1 :
    (strap_idx == 3'h2) ? `PRESET_SEQ2 :
    (strap_idx == 3'h3) ? `PRESET_SEQ3 :
    (strap_idx == 3'h4) ? `PRESET_SEQ4 :
    (strap_idx == 3'h5) ? `PRESET_SEQ5 : `PRESET_SEQ0;

  // capture once after reset; later strap changes are never looked at
  always_ff @(posedge clk) begin
    if (rst) begin
      settle_r <= 3'h0;
      strap_sel_r <= 3'h0;
    end else if (settle_r != `STRAP_SETTLE_CYC) begin
      settle_r <= settle_r + 3'h1;
    end else if (strap_take && (settle_r == `STRAP_SETTLE_CYC) && (state_r == ST_DETECT)) begin
      strap_sel_r <= strap_idx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // host settings registers

  logic [7:0] on_reg_r; // {on gap, buck2_order_code, switch_order_code}
  logic [7:0] off_reg_r; // {off gap, ldo4 code, buck3_order_code}
  wire wr_on = reg_wr && (reg_addr == `ON_DELAY_ORDER_OFS);
  wire wr_off = reg_wr && (reg_addr == `OFF_DELAY_ORDER_OFS);
  wire preset_load = strap_take && (state_r == ST_DETECT);

  // reset gives the factory preset; the strap preset replaces it once
  always_ff @(posedge clk) begin
    if (rst) begin
      on_reg_r <= {`TD_RESET, 6'(`PRESET_SEQ0)};
      off_reg_r <= {`TD_RESET, 6'(`PRESET_SEQ0 >> 6)};
    end else if (preset_load) begin
      on_reg_r <= {`TD_RESET, preset_codes[5:0]};
      off_reg_r <= {`TD_RESET, preset_codes[11:6]};
    end else begin
      if (wr_on) begin
        on_reg_r <= reg_wdata;
      end
      if (wr_off) begin
        off_reg_r <= reg_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  order_codes_t work_codes_r, work_codes_nxt; // orders frozen at enable rise
  logic [1:0] on_td_r, on_td_nxt; // on gap frozen at enable rise
  logic [1:0] off_td_r, off_td_nxt; // off gap frozen at enable rise
  logic [2:0] step_r, step_nxt; // current position in the order
  logic [3:0] ch_en_r, ch_en_nxt; // channel enables
  logic gap_start; // launch the gap timer
  logic [TW-1:0] gap_load; // gap length for the launch
  logic gap_done; // gap elapsed

  wire order_codes_t reg_codes = {off_reg_r[`CODE_HI_MSB:`CODE_LO_LSB], on_reg_r[`CODE_HI_MSB:`CODE_LO_LSB]};
  wire [3:0] cur_mask = chan_mask(work_codes_r, step_r);
  wire [3:0] next_mask = chan_mask(work_codes_r, step_r + 3'h1);
  wire [3:0] first_mask = chan_mask(reg_codes, 3'h1);
  wire [3:0] prev_mask = chan_mask(work_codes_r, step_r - 3'h1);
  wire step_good = ((good_s & cur_mask) == cur_mask);
  wire step_discharged = ((dis_s & cur_mask) == cur_mask);

  // gap counter shared by both directions
  gap_timer #(.W(TW)) u_gap (
    .clk(clk),
    .rst(rst),
    .start(gap_start),
    .load(gap_load),
    .done(gap_done)
  );

  // next-state logic
  always_comb begin
    state_nxt = state_r;
    work_codes_nxt = work_codes_r;
    on_td_nxt = on_td_r;
    off_td_nxt = off_td_r;
    step_nxt = step_r;
    ch_en_nxt = ch_en_r;
    gap_start = 1'b0;
    gap_load = '0;
    if (fault_s && (state_r != ST_DETECT)) begin
      // no ordered walk-down: everything drops in one cycle
      ch_en_nxt = 4'h0;
      state_nxt = ST_FAULT;
    end else begin
      unique case (state_r)
        ST_DETECT: begin
          if (preset_load) begin
            state_nxt = ST_OFF;
          end
        end
        ST_OFF: begin
          if (en_s) begin
            // host edits made until now are taken here, not mid-sequence
            work_codes_nxt = reg_codes;
            on_td_nxt = on_reg_r[`TD_MSB:`TD_LSB];
            off_td_nxt = off_reg_r[`TD_MSB:`TD_LSB];
            step_nxt = (first_mask == 4'h0) ? 3'h0 : 3'h1;
            ch_en_nxt = first_mask;
            state_nxt = (first_mask == 4'h0) ? ST_ON : ST_UP_WAIT;
          end
        end
        ST_UP_WAIT: begin
          if (!en_s) begin
            ch_en_nxt = ch_en_r & ~cur_mask;
            state_nxt = ST_DN_WAIT;
          end else if (step_good) begin
            gap_start = 1'b1;
            gap_load = td_cycles(on_td_r);
            state_nxt = ST_UP_GAP;
          end
        end
        ST_UP_GAP: begin
          if (!en_s) begin
            ch_en_nxt = ch_en_r & ~cur_mask;
            state_nxt = ST_DN_WAIT;
          end else if (gap_done) begin
            // a missing next code ends the walk-up; codes rely on host order
            if ((next_mask == 4'h0) || (step_r == 3'h7)) begin
              state_nxt = ST_ON;
            end else begin
              step_nxt = step_r + 3'h1;
              ch_en_nxt = ch_en_r | next_mask;
              state_nxt = ST_UP_WAIT;
            end
          end
        end
        ST_ON: begin
          if (!en_s) begin
            // last channel on is the first one off
            ch_en_nxt = ch_en_r & ~cur_mask;
            state_nxt = (step_r == 3'h0) ? ST_OFF : ST_DN_WAIT;
          end
        end
        ST_DN_WAIT: begin
          if (step_discharged) begin
            gap_start = 1'b1;
            gap_load = td_cycles(off_td_r);
            state_nxt = ST_DN_GAP;
          end
        end
        ST_DN_GAP: begin
          if (gap_done) begin
            if (step_r <= 3'h1) begin
              step_nxt = 3'h0;
              state_nxt = ST_OFF;
            end else begin
              step_nxt = step_r - 3'h1;
              ch_en_nxt = ch_en_r & ~prev_mask;
              state_nxt = ST_DN_WAIT;
            end
          end
        end
        ST_FAULT: begin
          // stay latched off until the host drops enable
          if (!en_s) begin
            state_nxt = ST_OFF;
          end
        end
      endcase
    end
  end

  // state registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ST_DETECT;
      work_codes_r <= '0;
      on_td_r <= `TD_RESET;
      off_td_r <= `TD_RESET;
      step_r <= 3'h0;
      ch_en_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      work_codes_r <= work_codes_nxt;
      on_td_r <= on_td_nxt;
      off_td_r <= off_td_nxt;
      step_r <= step_nxt;
      ch_en_r <= ch_en_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read port: data stands one cycle after the read strobe

  wire seq_moving = (state_r == ST_UP_WAIT) || (state_r == ST_UP_GAP) ||
                    (state_r == ST_DN_WAIT) || (state_r == ST_DN_GAP);
  wire [7:0] status_word = {state_r == ST_FAULT, state_r == ST_ON, seq_moving, 1'b0, ch_en_r};
  wire [7:0] rd_mux =
    (reg_addr == `ON_DELAY_ORDER_OFS) ? on_reg_r :
    (reg_addr == `OFF_DELAY_ORDER_OFS) ? off_reg_r :
    (reg_addr == `SEQ_STATUS_OFS) ? status_word :
    (reg_addr == `STRAP_SEL_OFS) ? {5'h00, strap_sel_r} : 8'h00; // unmapped reads zero

  // read data register; it holds zero outside the answer cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  assign ch_enable = ch_en_r;
  assign seq_busy = seq_moving;

endmodule

// ===== src/seq_consts.svh
// Notes on behaviour
// - supply plug-in resets every setting to default
// - new settings apply at next enable rise
// - six preset orderings chosen by strap pin
// - strap sampled once at plug-in only
// - default orders come from fixed factory constants
// - host writes per-channel order fields in registers
// - 3-bit code is position; 000 disables channel
// - on-delay register bits 7:6 set on gap
// - off-delay register bits 7:6 set off gap
// - power-down runs in reverse power-up order
// - fault turns all channels off at once
`ifndef SEQ_CONSTS_SVH
`define SEQ_CONSTS_SVH

// register offsets on the plain register port
`define ON_DELAY_ORDER_OFS 8'h01
`define OFF_DELAY_ORDER_OFS 8'h02
`define SEQ_STATUS_OFS 8'h03
`define STRAP_SEL_OFS 8'h04

// field positions inside the two order registers
`define TD_MSB 7
`define TD_LSB 6
`define CODE_HI_MSB 5
`define CODE_HI_LSB 3
`define CODE_LO_MSB 2
`define CODE_LO_LSB 0

// order presets packed {ldo4, buck3, buck2, load_switch}, 3 bits each
`define PRESET_SEQ0 12'h8CA
`define PRESET_SEQ1 12'h4E1
`define PRESET_SEQ2 12'h29C
`define PRESET_SEQ3 12'h88B
`define PRESET_SEQ4 12'h68C
`define PRESET_SEQ5 12'h711
`define PRESET_COUNT 3'h6

// delay field reset value
`define TD_RESET 2'h0

// timing: clock period, smallest nonzero gap step, strap settling
`define CLK_PERIOD_NS 10
`define TD_STEP_US 500
`define STRAP_SETTLE_CYC 3'h4

`endif

// ===== src/seq_pkg.sv
package seq_pkg;

  // sequencer states, one-hot
  typedef enum logic [7:0] {
    ST_DETECT = 8'h01,
    ST_OFF = 8'h02,
    ST_UP_WAIT = 8'h04,
    ST_UP_GAP = 8'h08,
    ST_ON = 8'h10,
    ST_DN_WAIT = 8'h20,
    ST_DN_GAP = 8'h40,
    ST_FAULT = 8'h80
  } seq_state_t;

  // packed order codes of the four sequenced channels
  typedef logic [11:0] order_codes_t;

endpackage

// ===== src/gap_timer.sv
`timescale 1ns/10ps
// one-shot down counter; a load of zero finishes on the next cycle
module gap_timer #(
  parameter int W = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [W-1:0] load,
  output logic done
);

  logic [W-1:0] cnt_r; // cycles still to wait
  logic run_r; // timer armed

  // done is a one-cycle pulse when the armed count reaches zero
  assign done = run_r && (cnt_r == '0);

  // load on start, then count down to zero
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
      run_r <= 1'b0;
    end else if (start) begin
      cnt_r <= load;
      run_r <= 1'b1;
    end else if (done) begin
      run_r <= 1'b0;
    end else if (run_r) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

endmodule

// ===== bench/seq_chk_sva.sv
`timescale 1ns/10ps
// port-level checker for the power order sequencer
module seq_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic en_pin,
  input wire logic fault_in,
  input wire logic [3:0] ch_good,
  input wire logic [3:0] ch_discharged,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [3:0] ch_enable,
  input wire logic seq_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  chk_reset_quiet: assert property ($fell(rst) |-> ch_enable == 4'h0 && !seq_busy)
    else $error("outputs active right after reset");
  chk_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside a read");
  chk_unmapped_zero: assert property (reg_rd && reg_addr > 8'h04 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_strap_range: assert property (reg_rd && reg_addr == 8'h04 |=> reg_rdata < 8'h06)
    else $error("preset index out of range");
  // a held fault clears every enable, whatever the step
  chk_fault_off: assert property (fault_in [*5] |-> ch_enable == 4'h0)
    else $error("channel on during fault");
  chk_no_up_low: assert property ((!en_pin) [*5] |-> (ch_enable & ~$past(ch_enable)) == 4'h0)
    else $error("channel turned on with enable low");
  chk_no_drop_high: assert property ((en_pin && !fault_in) [*6] |->
    ($past(ch_enable) & ~ch_enable) == 4'h0)
    else $error("channel dropped with enable high");
  // the next step waits for soft-start of all channels already on
  chk_up_after_good: assert property ((ch_enable & ~$past(ch_enable)) != 4'h0 |->
    (ch_good & $past(ch_enable)) == $past(ch_enable))
    else $error("step before soft-start done");
  chk_dn_after_dis: assert property (($past(ch_enable) & ~ch_enable) != 4'h0 && !fault_in |->
    (ch_discharged | $past(ch_enable)) == 4'hF)
    else $error("step before discharge done");
endmodule

bind pmic_power_order_sequencer seq_chk u_chk (.clk(clk), .rst(rst), .en_pin(en_pin), .fault_in(fault_in),
  .ch_good(ch_good), .ch_discharged(ch_discharged), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .ch_enable(ch_enable), .seq_busy(seq_busy));

// ===== bench/rail_model.sv
`timescale 1ns/10ps
// regulator rails: good or discharged some cycles after each enable change
module rail_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic [3:0] ch_enable,
  output logic [3:0] ch_good,
  output logic [3:0] ch_discharged
);
  logic [3:0] last_r; // enables seen last cycle
  logic [3:0] cnt_r [4]; // cycles since each enable changed
  logic [3:0] lim; // settle time, slow rails take longer
  assign lim = slow ? 4'hC : 4'h2;
  // count from each edge of an enable
  always_ff @(posedge clk) begin
    last_r <= rst ? 4'h0 : ch_enable;
    for (int i = 0; i < 4; i++) begin
      if (rst || ch_enable[i] != last_r[i]) begin
        cnt_r[i] <= 4'h0;
      end else if (cnt_r[i] != 4'hF) begin
        cnt_r[i] <= cnt_r[i] + 4'h1;
      end
    end
  end
  // flags only once the rail has settled
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ch_good[i] = last_r[i] && cnt_r[i] >= lim;
      ch_discharged[i] = !last_r[i] && cnt_r[i] >= lim;
    end
  end
endmodule

// ===== bench/pmic_power_order_sequencer_test.sv
`timescale 1ns/10ps
`include "seq_consts.svh"
module pmic_power_order_sequencer_test;
  localparam int STEP = 4; // short gap step keeps the run brief
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic en_pin = 1'b0;
  logic [2:0] order_strap_pin = 3'h0;
  logic fault_in = 1'b0;
  logic slow = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [3:0] ch_enable, ch_good, ch_discharged;
  logic seq_busy;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [3:0] seen[$]; // enables, one entry per change
  int stamp[$]; // cycle of each change
  logic [3:0] last_en = 4'h0;
  logic [11:0] pre [6] = '{`PRESET_SEQ0, `PRESET_SEQ1, `PRESET_SEQ2, `PRESET_SEQ3, `PRESET_SEQ4, `PRESET_SEQ5};
  always #5 clk = ~clk;
  pmic_power_order_sequencer #(.STEP_CYCLES(STEP), .TW(20)) DUT (.clk(clk), .rst(rst), .en_pin(en_pin),
    .order_strap_pin(order_strap_pin), .fault_in(fault_in), .ch_good(ch_good), .ch_discharged(ch_discharged),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ch_enable(ch_enable), .seq_busy(seq_busy));
  rail_model rails (.clk(clk), .rst(rst), .slow(slow), .ch_enable(ch_enable), .ch_good(ch_good),
    .ch_discharged(ch_discharged));
  ////////////////////////////////////////////////////////////
  // log every change of the enables
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (ch_enable !== last_en) begin
      seen.push_back(ch_enable);
      stamp.push_back(cyc);
    end
    last_en <= ch_enable;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
    @(posedge clk);
  endtask
  task automatic do_reset(input logic [2:0] s);
    order_strap_pin <= s;
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  // bounded wait for the stepping to finish
  task automatic wait_idle();
    repeat (8) @(posedge clk);
    for (int i = 0; i < 500 && seq_busy !== 1'b0; i++) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask
  // exp holds the expected enables, first change in the low nibble
  task automatic chk_seq(input logic [31:0] exp, input int n);
    chk(8'(seen.size()), 8'(n));
    for (int i = 0; i < n && i < seen.size(); i++) chk({4'h0, seen[i]}, {4'h0, exp[4*i+:4]});
    seen.delete();
    stamp.delete();
  endtask
  // step spacing is the programmed gap plus a fixed overhead: fast rail settling, two sync flops
  // and the state hops add about seven cycles, so the window is narrow enough to catch a wrong gap code
  task automatic chk_gap(input int gc);
    int d;
    chk(8'(stamp.size()), 8'h03);
    for (int i = 1; i < stamp.size(); i++) begin
      d = stamp[i] - stamp[i-1];
      chk(8'(d >= gc + 4 && d < gc + 10), 8'h01);
    end
    seen.delete();
    stamp.delete();
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    results();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    logic [11:0] p;
    // every strap code, straps 6 and 7 fall back to preset 0
    for (int s = 0; s < 8; s++) begin
      do_reset(3'(s));
      p = pre[s < 6 ? s : 0];
      rd(8'h01, {2'b00, p[5:0]});
      rd(8'h02, {2'b00, p[11:6]});
      rd(8'h04, 8'(s < 6 ? s : 0));
    end
    // let the new strap level pass the synchroniser, so only the one-shot capture keeps it out
    order_strap_pin <= 3'h5;
    repeat (6) @(posedge clk);
    rd(8'h04, 8'h00);
    wr(8'h01, 8'h55);
    rd(8'h01, 8'h55);
    wr(8'h04, 8'hFF);
    rd(8'h04, 8'h00);
    rd(8'h10, 8'h00);
    do_reset(3'h0);
    rd(8'h01, 8'h0A);
    $display("registers done");
    // the log still holds the unknown enables of power-on; start the ordering tests clean
    seen.delete();
    stamp.delete();
    // rewrite mid power-up; new order waits for the next enable
    slow <= 1'b1;
    en_pin <= 1'b1;
    repeat (8) @(posedge clk);
    chk({7'h00, seq_busy}, 8'h01);
    // new order runs from one with no gap and leaves the switch out
    wr(8'h01, 8'h08);
    wr(8'h02, 8'h1A);
    wait_idle();
    chk_seq(32'h0000F732, 4);
    en_pin <= 1'b0;
    wait_idle();
    chk_seq(32'h00000237, 4);
    en_pin <= 1'b1;
    wait_idle();
    chk_seq(32'h00000E62, 3);
    en_pin <= 1'b0;
    wait_idle();
    chk_seq(32'h00000026, 3);
    $display("ordering done");
    // every gap code, up and down
    slow <= 1'b0;
    for (int g = 3; g >= 0; g--) begin
      wr(8'h01, {2'(g), 6'h08});
      wr(8'h02, {2'(g), 6'h1A});
      for (int e = 1; e >= 0; e--) begin
        en_pin <= 1'(e);
        wait_idle();
        chk_gap(g == 3 ? 4 * STEP : g * STEP);
      end
    end
    $display("gaps done");
    // fault drops all at once and holds until enable cycles
    en_pin <= 1'b1;
    wait_idle();
    rd(8'h03, 8'h4E);
    chk_seq(32'h00000E62, 3);
    fault_in <= 1'b1;
    repeat (6) @(posedge clk);
    chk_seq(32'h00000000, 1);
    fault_in <= 1'b0;
    repeat (20) @(posedge clk);
    chk({4'h0, ch_enable}, 8'h00);
    rd(8'h03, 8'h80);
    en_pin <= 1'b0;
    repeat (10) @(posedge clk);
    en_pin <= 1'b1;
    wait_idle();
    chk({4'h0, ch_enable}, 8'h0E);
    $display("fault done");
    results();
  end
endmodule
